// ---- core/flash_part_params.svh ----
`ifndef FLASH_PART_PARAMS_SVH
`define FLASH_PART_PARAMS_SVH

// Register byte offsets
`define UPB_OFFSET        8'h00
`define FSZ_OFFSET        8'h04
`define STATUS_OFFSET     8'h08
`define FAULT_ADDR_OFFSET 8'h0C
`define FAULT_CNT_OFFSET  8'h10

// Base field position
`define UPB_MSB           19
`define UPB_LSB           11

// Status bit positions
`define ST_OVER_SIZE      0
`define ST_ACTIVE         1
`define ST_FAULT          2

// Reset values, default flash size and fault counter limit
`define UPB_RESET         9'h000
`define WORD_ZERO         32'h0000_0000
`define FSZ_DEFAULT       32'h0004_0000
`define FAULT_CNT_MAX     16'hFFFF
`endif

// ---- core/flash_part_pkg.sv ----
package flash_part_pkg;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic        user_mode;
    } fetch_query_t;

    typedef struct packed {
        logic        valid;
        logic        user_space;
        logic        fault;
        logic [31:0] addr;
    } fetch_answer_t;

    typedef enum logic {
        region_kernel,
        region_user
    } region_t;
endpackage

// ---- core/region_classify.sv ----
`include "flash_part_params.svh"
module region_classify (
    input  wire logic [31:0]           base_word, // Assembled partition base
    input  wire logic [31:0]           addr,      // Program flash offset to classify
    output      flash_part_pkg::region_t region   // Kernel or user space
);
    import flash_part_pkg::*;

    always_comb begin
        region = region_kernel;
        if (base_word != `WORD_ZERO && addr >= base_word) begin
            region = region_user;
        end
    end
endmodule

// ---- core/flash_user_partition_base.sv ----
// Implementation choices: the address-and-strobe port and the register offsets.
`include "flash_part_params.svh"
module flash_user_partition_base #(
    parameter logic [31:0] FLASH_SIZE = `FSZ_DEFAULT // Program flash size in bytes
) (
    input  wire logic                         clock,     // System clock, 10 MHz
    input  wire logic                         reset,     // Synchronous, active high
    input  wire flash_part_pkg::reg_req_t     reg_req,   // Register access request
    output logic [31:0]                       reg_rdata, // Read data, cycle after strobe
    input  wire flash_part_pkg::fetch_query_t query,     // Fetch classification request
    output flash_part_pkg::fetch_answer_t     answer,    // Classification result
    output logic [31:0]                       base_addr, // Current partition base
    output logic                              part_on    // User partition present
);
    import flash_part_pkg::*;

    logic [`UPB_MSB:`UPB_LSB] base_r;
    logic                     fault_r;
    logic [31:0]              fault_addr_r;
    logic [15:0]              fault_cnt_r;
    logic [31:0]              rdata_r;
    fetch_answer_t            answer_r;

    logic [31:0]              base_word;
    logic                     over_size;
    logic                     fault_set;
    logic                     fault_clr;
    region_t                  region;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // Place the stored field; bits above and below it are constant zero
    function automatic logic [31:0] widen_base(input logic [`UPB_MSB:`UPB_LSB] f);
        logic [31:0] w;
        w = `WORD_ZERO;
        w[`UPB_MSB:`UPB_LSB] = f;
        widen_base = w;
    endfunction

    assign base_word = widen_base(base_r);

    // Software is expected to stay within flash; flag it when it does not
    assign over_size = (base_word > FLASH_SIZE);

    region_classify u_classify (
        .base_word (base_word),
        .addr      (query.addr),
        .region    (region)
    );

    // User-mode fetch into kernel space is a protection fault
    assign fault_set = query.valid && query.user_mode && (region == region_kernel);
    assign fault_clr = reg_req.wr && hit(reg_req.addr, `STATUS_OFFSET)
                       && reg_req.wdata[`ST_FAULT];

    // Base field storage
    always_ff @(posedge clock) begin
        if (reset) begin
            base_r <= `UPB_RESET;
        end else if (reg_req.wr && hit(reg_req.addr, `UPB_OFFSET)) begin
            base_r <= reg_req.wdata[`UPB_MSB:`UPB_LSB];
        end
    end

    // Sticky fault flag; a new fault wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            fault_r <= 1'b0;
        end else if (fault_set) begin
            fault_r <= 1'b1;
        end else if (fault_clr) begin
            fault_r <= 1'b0;
        end
    end

    // Address of the most recent fault
    always_ff @(posedge clock) begin
        if (reset) begin
            fault_addr_r <= `WORD_ZERO;
        end else if (fault_set) begin
            fault_addr_r <= query.addr;
        end
    end

    // Saturating fault counter, cleared by any write to it; a new fault wins over the clear
    always_ff @(posedge clock) begin
        if (reset) begin
            fault_cnt_r <= 16'h0000;
        end else if (fault_set) begin
            if (fault_cnt_r != `FAULT_CNT_MAX) begin
                fault_cnt_r <= fault_cnt_r + 16'h0001;
            end
        end else if (reg_req.wr && hit(reg_req.addr, `FAULT_CNT_OFFSET)) begin
            fault_cnt_r <= 16'h0000;
        end
    end

    // Classification answer, one cycle after the query
    always_ff @(posedge clock) begin
        if (reset) begin
            answer_r <= '0;
        end else begin
            answer_r.valid      <= query.valid;
            answer_r.user_space <= query.valid && (region == region_user);
            answer_r.fault      <= fault_set;
            answer_r.addr       <= query.valid ? query.addr : `WORD_ZERO;
        end
    end

    // Read data, valid only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_r <= `WORD_ZERO;
        end else if (reg_req.rd) begin
            unique case (reg_req.addr)
                `UPB_OFFSET:        rdata_r <= base_word;
                `FSZ_OFFSET:        rdata_r <= FLASH_SIZE;
                `STATUS_OFFSET:     rdata_r <= {29'h0000_0000, fault_r, base_r != `UPB_RESET,
                                                over_size};
                `FAULT_ADDR_OFFSET: rdata_r <= fault_addr_r;
                `FAULT_CNT_OFFSET:  rdata_r <= {16'h0000, fault_cnt_r};
                default:            rdata_r <= `WORD_ZERO;
            endcase
        end else begin
            rdata_r <= `WORD_ZERO;
        end
    end

    assign reg_rdata = rdata_r;
    assign answer    = answer_r;
    assign base_addr = base_word;
    assign part_on   = (base_r != `UPB_RESET);
endmodule

// ---- dv/flash_part_checker.sv ----
module flash_part_checker #(
    parameter logic [31:0] FLASH_SIZE = 32'h0004_0000 // Program flash size in bytes
) (
    input wire logic                          clock,     // System clock
    input wire logic                          reset,     // Synchronous reset
    input wire flash_part_pkg::reg_req_t      reg_req,   // Register request
    input wire logic [31:0]                   reg_rdata, // Read data
    input wire flash_part_pkg::fetch_query_t  query,     // Fetch query
    input wire flash_part_pkg::fetch_answer_t answer,    // Fetch answer
    input wire logic [31:0]                   base_addr, // Partition base
    input wire logic                          part_on    // Partition present
);
    timeunit 1ns;
    timeprecision 1ns;
    import flash_part_pkg::*;

    logic [8:0] field_r;
    always_ff @(posedge clock) begin
        field_r <= reg_req.wdata[19:11];
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    a_read_clean: assert property (
        reg_req.rd && reg_req.addr == 8'h00 |=>
        reg_rdata[31:20] == 12'h000 && reg_rdata[10:0] == 11'h000)
        else $error("base read shows fixed bits");
    a_read_base: assert property (reg_req.rd && reg_req.addr == 8'h00 |=>
        reg_rdata == $past(base_addr))
        else $error("base read differs from stored base");
    a_field_hold: assert property (!(reg_req.wr && reg_req.addr == 8'h00) |=>
        $stable(base_addr))
        else $error("base changed without a write");
    a_base_aligned: assert property (base_addr[10:0] == 11'h000 && base_addr[31:20] == 12'h000)
        else $error("base has bits outside field");
    a_write_held: assert property (reg_req.wr && reg_req.addr == 8'h00 |=> base_addr[19:11] == field_r)
        else $error("base field not written");
    a_reset_clears: assert property (disable iff (1'b0) reset |=> base_addr == 32'h0000_0000 && !part_on)
        else $error("base not cleared by reset");
    a_flag_match: assert property (part_on == (base_addr != 32'h0000_0000))
        else $error("partition flag wrong");
    a_user_split: assert property (query.valid |=> answer.valid &&
        answer.user_space == ($past(query.addr) >= $past(base_addr)
        && $past(base_addr) != 32'h0000_0000)
        && answer.fault == ($past(query.user_mode) && !answer.user_space))
        else $error("fetch class wrong");
endmodule
bind flash_user_partition_base flash_part_checker #(.FLASH_SIZE(FLASH_SIZE)) i_flash_part_checker (
    .clock(clock), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata), .query(query),
    .answer(answer), .base_addr(base_addr), .part_on(part_on));

// ---- dv/tb_top.sv ----
`include "flash_part_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import flash_part_pkg::*;
    logic clock = 0, reset = 1, part_on, seen = 0;
    logic [31:0] reg_rdata, base_addr, seed = 32'h0000_0060, d, e, la = 32'h0000_0000, q[$];
    logic [33:0] qa[$], x;
    reg_req_t reg_req = '0;
    fetch_query_t query = '0;
    fetch_answer_t answer;
    int num_errors = 0, n_compared = 0, nf = 0;
    always #50 clock = ~clock;
    flash_user_partition_base i_flash_user_partition_base (.clock(clock), .reset(reset),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .query(query), .answer(answer),
        .base_addr(base_addr), .part_on(part_on));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(logic [31:0] got, logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(logic [7:0] a, logic [31:0] dv, logic w, logic r, logic [31:0] ex);
        reg_req <= '{a, dv, w, r};
        query <= '0;
        if (r) q.push_back(ex);
        @(posedge clock);
    endtask
    // Notes the expected answer {addr, fault, user space} and the expected fault record
    task automatic ask(logic [31:0] a, logic um);
        logic u;
        u = a >= e && e != 32'h0000_0000;
        reg_req <= '0;
        query <= '{1'b1, a, um};
        qa.push_back({a, um && !u, u});
        if (um && !u) begin
            nf++;
            la = a;
        end
        @(posedge clock);
    endtask
    task automatic idle();
        reg_req <= '0;
        query <= '0;
        repeat (2) @(posedge clock);
    endtask
    task automatic results();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        if (seen) check(reg_rdata, q.pop_front());
        if (answer.valid === 1'b1) begin
            x = qa.pop_front();
            check({30'b0, answer.fault, answer.user_space}, {30'b0, x[1:0]});
            check(answer.addr, x[33:2]);
        end
        seen <= reg_req.rd;
    end
    initial begin
        repeat (10) @(posedge clock);
        reset <= 0;
        e = 0;
        bus(`UPB_OFFSET, 0, 0, 1, 0);
        ask(32'h0000_0800, 1'b1);
        idle();
        check({31'b0, part_on}, 0);
        check(base_addr, 0);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            d = xs() & 32'hFFF3_FFFF;
            e = d & 32'h000F_F800;
            bus(`UPB_OFFSET, d, 1, 0, 0);
            bus(`UPB_OFFSET, 0, 0, 1, e);
            check(base_addr, e);
            check({31'b0, part_on}, {31'b0, e != 0});
            ask(e, d[0]);
            ask(e - 1, 1'b1);
            idle();
        end
        $display("base test done");
        bus(`STATUS_OFFSET, 0, 0, 1, {29'b0, nf != 0, e != 0, 1'b0});
        bus(`FAULT_ADDR_OFFSET, 0, 0, 1, la);
        bus(`FAULT_CNT_OFFSET, 0, 0, 1, nf);
        bus(`FSZ_OFFSET, 0, 0, 1, `FSZ_DEFAULT);
        bus(`STATUS_OFFSET, 32'h0000_0004, 1, 0, 0);
        bus(`FAULT_CNT_OFFSET, 0, 1, 0, 0);
        bus(`STATUS_OFFSET, 0, 0, 1, {30'b0, e != 0, 1'b0});
        bus(`FAULT_CNT_OFFSET, 0, 0, 1, 0);
        idle();
        $display("status test done");
        bus(8'h40, xs(), 1, 0, 0);
        bus(8'h40, 0, 0, 1, 0);
        bus(`UPB_OFFSET, 0, 0, 1, e);
        idle();
        reset <= 1;
        @(posedge clock);
        reset <= 0;
        e = 0;
        bus(`UPB_OFFSET, 0, 0, 1, 0);
        bus(`STATUS_OFFSET, 0, 0, 1, 0);
        idle();
        $display("unmapped and reset test done");
        results();
    end
    initial begin
        #200000;
        num_errors++;
        results();
    end
endmodule
